// [rtl/phy_mac_sel_regs.svh]
// Register indices, fields, resets and counts.
// Assumes byte address = four times index.
// Function
// - Serial enable wins; RGMII needs it clear.
// - Strap pin level loads serial enable.
// - Strap levels kept in strap status.
// - Serial link runs 1.25 Gbps.
// - Serial timing recovered locally.
// - Four wires; receive clock pair on request.
// - 100 Mbps serial bytes sent ten times.
// - Start delimiter once per frame.
// - In-band negotiation by default.
// - Control words follow media speed.
// - Negotiation off forces media speed.
// - Forcing works for any media speed mode.
// - Loopback speed follows media speed.
// - 10 Mbps adapts without rate-adapt bit.
// - RGMII both edges; 125, 25, 2.5 MHz.
// - Gigabit: low nibble rising, high falling.
// - Control high in frames, low between.
// - Slow speeds repeat rising data falling.
`ifndef PHY_MAC_SEL_REGS_SVH
`define PHY_MAC_SEL_REGS_SVH

`define IDX_PHY_CONTROL 10'h010
`define IDX_CONFIG_TWO 10'h014
`define IDX_RGMII_CONTROL 10'h032
`define IDX_STRAP_STATUS_ONE 10'h06E
`define IDX_IFACE_STATUS 10'h06F

`define BIT_SERIAL_EN 11
`define BIT_RGMII_EN 7
`define BIT_INBAND_NEG 8
`define BIT_SIX_WIRE 6
`define STRAP_BIT_SERIAL 0
`define STRAP_BIT_RGMII_DIS 1
`define ST_MODE_LSB 0
`define ST_SPEED_LSB 4
`define ST_AN_LSB 8

`define RST_PHY_CONTROL 16'h0000
`define RST_CONFIG_TWO 16'h0100
`define RST_RGMII_CONTROL 16'h0000
`define STRAP_WAIT_LAST 2'h2

`define REP_1000 7'h01
`define REP_100 7'h0A
`define REP_10 7'h64

`define PCLK_PERIOD_PS 8000
`define RGMII_PER_1000_PS 8000
`define RGMII_PER_100_PS 40000
`define RGMII_PER_10_PS 400000

`define K28_5 8'hBC
`define D16_2 8'h50
`define D21_5 8'hB5
`define K27_7 8'hFB
`define K29_7 8'hFD
`define K23_7 8'hF7

`define CFG_BIT_LINK 15
`define CFG_BIT_ACK 14
`define CFG_BIT_DUPLEX 12
`define CFG_SPEED_LSB 10
`define CFG_BIT_SGMII 0

`endif

// [rtl/mac_if_pkg.sv]
// Types shared by the MAC interface select block.
// Assumes nothing.
package mac_if_pkg;
  typedef enum logic [2:0] {MODE_NONE = 3'h1, MODE_SGMII = 3'h2, MODE_RGMII = 3'h4} mode_t;
  typedef enum logic [1:0] {SPEED_10 = 2'h0, SPEED_100 = 2'h1, SPEED_1000 = 2'h2} speed_t;
  typedef enum logic [2:0] {AN_CONFIG = 3'h1, AN_LINKED = 3'h2, AN_FORCED = 3'h4} an_state_t;
  typedef enum logic [5:0] {TX_IDLE_K = 6'h01, TX_IDLE_D = 6'h02, TX_CFG = 6'h04, TX_SOP = 6'h08,
                            TX_DATA = 6'h10, TX_CAR = 6'h20} tx_state_t;
  // Media-side byte stream
  typedef struct packed {logic valid; logic dv; logic er; logic [7:0] data;} byte_stream_t;
  // Code group before coding
  typedef struct packed {logic k; logic [7:0] data;} code_group_t;
  // Both pclk halves for RGMII DDR cells
  typedef struct packed {logic clk_rise; logic clk_fall; logic ctl_rise; logic ctl_fall;
                         logic [3:0] d_rise; logic [3:0] d_fall;} rgmii_ddr_t;
endpackage : mac_if_pkg

// [rtl/sync2.sv]
// Two-flop pin synchronizer.
// Assumes slow levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : sync2

// [rtl/byte_replicator.sv]
// Repeats each byte rep_count cycles.
// Assumes the next byte is offered on the last copy.
`timescale 1ns/1ps
module byte_replicator #(
  parameter int CW = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CW-1:0] rep_count,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data
);
  logic [CW-1:0] left_ff;
  logic [7:0] byte_ff;
  wire take = in_valid & in_ready;

  // Ready on the last copy keeps the stream gapless
  assign in_ready = (left_ff <= CW'(1'h1));
  assign out_valid = (left_ff != '0);
  assign out_data = byte_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= '0;
      byte_ff <= 8'h00;
    end else if (take) begin
      left_ff <= rep_count;
      byte_ff <= in_data;
    end else if (out_valid) begin
      left_ff <= left_ff - CW'(1'h1);
    end
  end
endmodule : byte_replicator

// [rtl/phy_mac_interface_select.sv]
// MAC interface select: serial code groups or RGMII, APB registers.
// Assumes an external serializer with clock recovery and RGMII DDR cells.
`timescale 1ns/1ps
`include "phy_mac_sel_regs.svh"
module phy_mac_interface_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_enable_strap_pin,
  input wire logic rgmii_disable_strap_pin,
  input wire mac_if_pkg::speed_t media_speed,
  input wire logic media_link,
  input wire logic mac_loopback,
  input wire mac_if_pkg::byte_stream_t core_rx,
  output logic core_rx_ready,
  output mac_if_pkg::byte_stream_t core_tx,
  input wire mac_if_pkg::code_group_t ser_rx,
  input wire logic ser_rx_cfg_ack,
  output mac_if_pkg::code_group_t ser_tx,
  output logic ser_rx_clk_en,
  input wire logic rgmii_txc,
  input wire logic [3:0] rgmii_txd,
  input wire logic rgmii_tx_ctl,
  output mac_if_pkg::rgmii_ddr_t rgmii_rx
);
  // Half-cycles of pclk per RGMII clock period
  localparam logic [7:0] HALVES_1000 = 8'((`RGMII_PER_1000_PS * 2) / `PCLK_PERIOD_PS);
  localparam logic [7:0] HALVES_100 = 8'((`RGMII_PER_100_PS * 2) / `PCLK_PERIOD_PS);
  localparam logic [7:0] HALVES_10 = 8'((`RGMII_PER_10_PS * 2) / `PCLK_PERIOD_PS);

  // Pin synchronisers
  logic [7:0] pin_s;
  sync2 #(.W(8)) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({serial_enable_strap_pin, rgmii_disable_strap_pin, rgmii_tx_ctl, rgmii_txc, rgmii_txd}),
    .q(pin_s)
  );
  wire ser_strap_s = pin_s[7];
  wire rgmii_dis_s = pin_s[6];
  wire txctl_s = pin_s[5];
  wire txc_s = pin_s[4];
  wire [3:0] txd_s = pin_s[3:0];

  // Straps caught once the synchroniser has settled
  logic [1:0] strap_wait_ff;
  logic strap_done_ff;
  wire strap_load = ~strap_done_ff & (strap_wait_ff == `STRAP_WAIT_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      strap_done_ff <= strap_load;
    end
  end

  // APB decode; zero wait states, error on unmapped index
  logic [15:0] phy_control_ff;
  logic [15:0] config_two_ff;
  logic [15:0] rgmii_control_ff;
  logic [15:0] strap_status_one_ff;
  logic [15:0] iface_status;
  logic [31:0] prdata_ff;
  wire [9:0] reg_idx = paddr[11:2];
  wire hit_pc = (reg_idx == `IDX_PHY_CONTROL);
  wire hit_c2 = (reg_idx == `IDX_CONFIG_TWO);
  wire hit_rg = (reg_idx == `IDX_RGMII_CONTROL);
  wire hit_ss = (reg_idx == `IDX_STRAP_STATUS_ONE);
  wire hit_is = (reg_idx == `IDX_IFACE_STATUS);
  wire hit_any = hit_pc | hit_c2 | hit_rg | hit_ss | hit_is;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire [15:0] rd_mux = hit_pc ? phy_control_ff :
                       hit_c2 ? config_two_ff :
                       hit_rg ? rgmii_control_ff :
                       hit_ss ? strap_status_one_ff :
                       hit_is ? iface_status : 16'h0000;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_ff;

  // Next values; strap load beats a same-cycle write
  logic [15:0] nxt_phy_control;
  logic [15:0] nxt_rgmii_control;
  logic [15:0] nxt_strap_status_one;
  always_comb begin
    nxt_phy_control = (apb_wr & hit_pc) ? pwdata[15:0] : phy_control_ff;
    nxt_rgmii_control = (apb_wr & hit_rg) ? pwdata[15:0] : rgmii_control_ff;
    nxt_strap_status_one = strap_status_one_ff;
    if (strap_load) begin
      nxt_phy_control[`BIT_SERIAL_EN] = ser_strap_s;
      nxt_rgmii_control[`BIT_RGMII_EN] = ~rgmii_dis_s;
      nxt_strap_status_one[`STRAP_BIT_SERIAL] = ser_strap_s;
      nxt_strap_status_one[`STRAP_BIT_RGMII_DIS] = rgmii_dis_s;
    end
  end
  wire [15:0] nxt_config_two = (apb_wr & hit_c2) ? pwdata[15:0] : config_two_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_control_ff <= `RST_PHY_CONTROL;
      config_two_ff <= `RST_CONFIG_TWO;
      rgmii_control_ff <= `RST_RGMII_CONTROL;
      strap_status_one_ff <= 16'h0000;
      prdata_ff <= 32'h0000_0000;
    end else begin
      phy_control_ff <= nxt_phy_control;
      config_two_ff <= nxt_config_two;
      rgmii_control_ff <= nxt_rgmii_control;
      strap_status_one_ff <= nxt_strap_status_one;
      prdata_ff <= (apb_setup & ~pwrite) ? {16'h0000, rd_mux} : prdata_ff;
    end
  end

  // Serial enable has priority
  mac_if_pkg::mode_t mode;
  wire ser_en = phy_control_ff[`BIT_SERIAL_EN];
  wire rg_en = rgmii_control_ff[`BIT_RGMII_EN];
  assign mode = ser_en ? mac_if_pkg::MODE_SGMII :
                rg_en ? mac_if_pkg::MODE_RGMII : mac_if_pkg::MODE_NONE;
  wire is_ser = (mode == mac_if_pkg::MODE_SGMII);
  wire is_rg = (mode == mac_if_pkg::MODE_RGMII);
  wire inband_en = config_two_ff[`BIT_INBAND_NEG];
  wire loop_on = is_ser & mac_loopback;

  // Fifth and sixth wires only on request
  assign ser_rx_clk_en = is_ser & config_two_ff[`BIT_SIX_WIRE];

  // Speed counts; 10 Mbps ignores the stored rate-adapt bit
  logic [6:0] rep_count;
  logic [7:0] halves;
  always_comb begin
    case (media_speed)
      mac_if_pkg::SPEED_10: begin
        rep_count = `REP_10;
        halves = HALVES_10;
      end
      mac_if_pkg::SPEED_100: begin
        rep_count = `REP_100;
        halves = HALVES_100;
      end
      default: begin
        rep_count = `REP_1000;
        halves = HALVES_1000;
      end
    endcase
  end

  // In-band negotiation
  mac_if_pkg::an_state_t an_ff;
  mac_if_pkg::an_state_t nxt_an;
  mac_if_pkg::speed_t last_speed_ff;
  logic last_link_ff;
  wire an_restart = (media_speed != last_speed_ff) | (media_link != last_link_ff);
  always_comb begin
    nxt_an = an_ff;
    case (an_ff)
      mac_if_pkg::AN_CONFIG: begin
        if (!inband_en) begin
          nxt_an = mac_if_pkg::AN_FORCED;
        end else if (ser_rx_cfg_ack) begin
          nxt_an = mac_if_pkg::AN_LINKED;
        end
      end
      mac_if_pkg::AN_LINKED: begin
        if (!inband_en) begin
          nxt_an = mac_if_pkg::AN_FORCED;
        end else if (an_restart) begin
          nxt_an = mac_if_pkg::AN_CONFIG;
        end
      end
      mac_if_pkg::AN_FORCED: begin
        if (inband_en) begin
          nxt_an = mac_if_pkg::AN_CONFIG;
        end
      end
      default: nxt_an = mac_if_pkg::AN_CONFIG;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_ff <= mac_if_pkg::AN_CONFIG;
      last_speed_ff <= mac_if_pkg::SPEED_10;
      last_link_ff <= 1'b0;
    end else begin
      an_ff <= nxt_an;
      last_speed_ff <= media_speed;
      last_link_ff <= media_link;
    end
  end
  wire an_cfg = (an_ff == mac_if_pkg::AN_CONFIG);

  // Advertised control word
  logic [15:0] cfg_word;
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[`CFG_BIT_SGMII] = 1'b1;
    cfg_word[`CFG_BIT_DUPLEX] = 1'b1;
    cfg_word[`CFG_BIT_LINK] = media_link;
    cfg_word[`CFG_BIT_ACK] = ser_rx_cfg_ack;
    cfg_word[`CFG_SPEED_LSB +: 2] = media_speed;
  end

  // Media bytes replicated toward the link
  logic rep_in_ready;
  logic rep_out_valid;
  logic [7:0] rep_out_data;
  mac_if_pkg::tx_state_t tx_state_ff;
  mac_if_pkg::tx_state_t nxt_tx_state;
  wire tx_in_frame = (tx_state_ff == mac_if_pkg::TX_SOP) | (tx_state_ff == mac_if_pkg::TX_DATA);
  wire rep_in_valid = is_ser & ~loop_on & tx_in_frame & core_rx.valid & core_rx.dv;
  byte_replicator #(.CW(7)) u_rep (
    .clk(pclk),
    .rst_n(presetn),
    .rep_count(rep_count),
    .in_valid(rep_in_valid),
    .in_data(core_rx.data),
    .in_ready(rep_in_ready),
    .out_valid(rep_out_valid),
    .out_data(rep_out_data)
  );

  // Serial transmit: idles, control words, framed copies
  mac_if_pkg::code_group_t nxt_code;
  logic [1:0] cfg_pos_ff;
  logic [1:0] nxt_cfg_pos;
  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_cfg_pos = 2'h0;
    nxt_code = '{k: 1'b0, data: 8'h00};
    case (tx_state_ff)
      mac_if_pkg::TX_IDLE_K: begin
        nxt_code = '{k: 1'b1, data: `K28_5};
        nxt_tx_state = an_cfg ? mac_if_pkg::TX_CFG : mac_if_pkg::TX_IDLE_D;
      end
      mac_if_pkg::TX_IDLE_D: begin
        nxt_code = '{k: 1'b0, data: `D16_2};
        nxt_tx_state = (core_rx.valid & core_rx.dv) ? mac_if_pkg::TX_SOP : mac_if_pkg::TX_IDLE_K;
      end
      mac_if_pkg::TX_CFG: begin
        nxt_cfg_pos = cfg_pos_ff + 2'h1;
        nxt_code.data = (cfg_pos_ff == 2'h0) ? `D21_5 : (cfg_pos_ff == 2'h1) ? cfg_word[7:0] : cfg_word[15:8];
        nxt_tx_state = (cfg_pos_ff == 2'h2) ? mac_if_pkg::TX_IDLE_K : mac_if_pkg::TX_CFG;
      end
      mac_if_pkg::TX_SOP: begin
        nxt_code = '{k: 1'b1, data: `K27_7};
        nxt_tx_state = mac_if_pkg::TX_DATA;
      end
      mac_if_pkg::TX_DATA: begin
        if (rep_out_valid) begin
          nxt_code = '{k: 1'b0, data: rep_out_data};
        end else begin
          nxt_code = '{k: 1'b1, data: `K29_7};
          nxt_tx_state = mac_if_pkg::TX_CAR;
        end
      end
      mac_if_pkg::TX_CAR: begin
        nxt_code = '{k: 1'b1, data: `K23_7};
        nxt_tx_state = mac_if_pkg::TX_IDLE_K;
      end
      default: nxt_tx_state = mac_if_pkg::TX_IDLE_K;
    endcase
  end

  // Loopback echoes the MAC's code groups
  mac_if_pkg::code_group_t ser_tx_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff <= mac_if_pkg::TX_IDLE_K;
      cfg_pos_ff <= 2'h0;
      ser_tx_ff <= '{k: 1'b0, data: 8'h00};
    end else begin
      tx_state_ff <= (is_ser & ~loop_on) ? nxt_tx_state : mac_if_pkg::TX_IDLE_K;
      cfg_pos_ff <= nxt_cfg_pos;
      ser_tx_ff <= ~is_ser ? '{k: 1'b0, data: 8'h00} : loop_on ? ser_rx : nxt_code;
    end
  end
  assign ser_tx = ser_tx_ff;

  // Serial receive: first copy of each byte
  logic drx_frame_ff;
  logic [6:0] drx_cnt_ff;
  wire drx_sop = ser_rx.k & (ser_rx.data == `K27_7);
  wire drx_byte = drx_frame_ff & ~ser_rx.k;
  wire drx_emit = drx_byte & (drx_cnt_ff == 7'h00);
  wire [6:0] drx_cnt_inc = drx_cnt_ff + 7'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drx_frame_ff <= 1'b0;
      drx_cnt_ff <= 7'h00;
    end else if (drx_sop) begin
      drx_frame_ff <= 1'b1;
      drx_cnt_ff <= 7'h00;
    end else if (drx_byte) begin
      drx_cnt_ff <= (drx_cnt_inc == rep_count) ? 7'h00 : drx_cnt_inc;
    end else if (ser_rx.k) begin
      drx_frame_ff <= 1'b0;
    end
  end
  wire mac_if_pkg::byte_stream_t ser_word = '{valid: drx_emit, dv: drx_emit, er: 1'b0, data: ser_rx.data};

  // RGMII transmit capture on sampled clock edges
  logic txc_last_ff;
  logic ctl_rise_ff;
  logic nib_half_ff;
  logic [3:0] lo_nib_ff;
  mac_if_pkg::byte_stream_t rg_word_ff;
  wire gig = (media_speed == mac_if_pkg::SPEED_1000);
  wire txc_rise = txc_s & ~txc_last_ff;
  wire txc_fall = ~txc_s & txc_last_ff;
  wire slow_emit = txc_rise & ~gig & nib_half_ff & txctl_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_last_ff <= 1'b0;
      ctl_rise_ff <= 1'b0;
      nib_half_ff <= 1'b0;
      lo_nib_ff <= 4'h0;
      rg_word_ff <= '{valid: 1'b0, dv: 1'b0, er: 1'b0, data: 8'h00};
    end else begin
      txc_last_ff <= txc_s;
      if (txc_rise) begin
        ctl_rise_ff <= txctl_s;
        lo_nib_ff <= (gig | ~nib_half_ff) ? txd_s : lo_nib_ff;
        nib_half_ff <= ~gig & txctl_s & ~nib_half_ff;
      end
      if (txc_fall & gig) begin
        rg_word_ff <= '{valid: ctl_rise_ff, dv: ctl_rise_ff, er: ctl_rise_ff ^ txctl_s,
                        data: {txd_s, lo_nib_ff}};
      end else if (slow_emit) begin
        rg_word_ff <= '{valid: 1'b1, dv: 1'b1, er: 1'b0, data: {txd_s, lo_nib_ff}};
      end else begin
        rg_word_ff.valid <= 1'b0;
      end
    end
  end

  // Core stream from the selected side
  mac_if_pkg::byte_stream_t core_tx_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_tx_ff <= '{valid: 1'b0, dv: 1'b0, er: 1'b0, data: 8'h00};
    end else begin
      core_tx_ff <= (is_ser & ~loop_on) ? ser_word : is_rg ? rg_word_ff : '0;
    end
  end
  assign core_tx = core_tx_ff;

  // RGMII receive clock and data in half-cycle steps
  logic [7:0] ph_ff;
  logic rg_hi_ff;
  logic [7:0] rg_byte_ff;
  logic rg_dv_ff;
  logic rg_er_ff;
  mac_if_pkg::rgmii_ddr_t rgmii_rx_ff;
  wire [7:0] half_pt = {1'b0, halves[7:1]};
  wire [7:0] ph_next = ph_ff + 8'h02;
  wire period_start = (ph_ff == 8'h00);
  wire need_byte = gig | ~rg_hi_ff;
  wire rg_take = is_rg & period_start & need_byte & core_rx.valid;
  wire [3:0] nib_now = rg_hi_ff ? rg_byte_ff[7:4] : core_rx.data[3:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ff <= 8'h00;
      rg_hi_ff <= 1'b0;
      rg_byte_ff <= 8'h00;
      rg_dv_ff <= 1'b0;
      rg_er_ff <= 1'b0;
      rgmii_rx_ff <= '0;
    end else begin
      ph_ff <= (ph_next >= halves) ? 8'h00 : ph_next;
      if (period_start) begin
        rg_hi_ff <= ~gig & ~rg_hi_ff & rg_take;
      end
      if (rg_take) begin
        rg_byte_ff <= core_rx.data;
        rg_dv_ff <= core_rx.dv;
        rg_er_ff <= core_rx.er;
      end else if (period_start & need_byte) begin
        rg_dv_ff <= 1'b0;
        rg_er_ff <= 1'b0;
      end
      if (!is_rg) begin
        rgmii_rx_ff <= '0;
      end else begin
        rgmii_rx_ff.clk_rise <= (ph_ff < half_pt);
        rgmii_rx_ff.clk_fall <= ((ph_ff + 8'h01) < half_pt);
        if (period_start) begin
          rgmii_rx_ff.ctl_rise <= rg_take ? core_rx.dv : rg_hi_ff & rg_dv_ff;
          rgmii_rx_ff.ctl_fall <= rg_take ? core_rx.dv ^ core_rx.er : rg_hi_ff & (rg_dv_ff ^ rg_er_ff);
          rgmii_rx_ff.d_rise <= (rg_take | rg_hi_ff) ? nib_now : 4'h0;
          rgmii_rx_ff.d_fall <= gig ? (rg_take ? core_rx.data[7:4] : 4'h0) : (rg_take | rg_hi_ff) ? nib_now : 4'h0;
        end
      end
    end
  end
  assign rgmii_rx = rgmii_rx_ff;
  assign core_rx_ready = (is_ser & ~loop_on & tx_in_frame & rep_in_ready & core_rx.dv) | rg_take;

  // Live status for software
  always_comb begin
    iface_status = 16'h0000;
    iface_status[`ST_MODE_LSB +: 3] = mode;
    iface_status[`ST_SPEED_LSB +: 2] = media_speed;
    iface_status[`ST_AN_LSB +: 3] = an_ff;
  end
endmodule : phy_mac_interface_select

// [dv/mac_if_sva.sv]
// Port checker.
// Assumes one pclk domain.
`timescale 1ns/1ps
`include "phy_mac_sel_regs.svh"
module mac_if_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire mac_if_pkg::speed_t media_speed,
  input wire logic mac_loopback,
  input wire mac_if_pkg::code_group_t ser_rx,
  input wire mac_if_pkg::code_group_t ser_tx,
  input wire logic ser_rx_clk_en,
  input wire mac_if_pkg::rgmii_ddr_t rgmii_rx
);
  logic six_ff;
  logic neg_ff;
  wire cfg_wr = psel && penable && pwrite && paddr[11:2] == `IDX_CONFIG_TWO;
  // Shadow of config two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      six_ff <= 1'b0;
      neg_ff <= 1'b1;
    end else if (cfg_wr) begin
      six_ff <= pwdata[`BIT_SIX_WIRE];
      neg_ff <= pwdata[`BIT_INBAND_NEG];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sop; ser_tx == {1'b1, `K27_7} |=> ser_tx != {1'b1, `K27_7}; endproperty
  a_sop: assert property (p_sop) else $error("start delimiter repeated");
  property p_rep; ser_tx == {1'b1, `K27_7} && media_speed == mac_if_pkg::SPEED_100 |=> ##1 $stable(ser_tx)[*8];
  endproperty
  a_rep: assert property (p_rep) else $error("byte copies too short");
  property p_four; !six_ff |-> !ser_rx_clk_en; endproperty
  a_four: assert property (p_four) else $error("unrequested clock pair");
  property p_forced; !neg_ff && $past(neg_ff, 8) == 1'b0 && ser_tx == {1'b1, `K28_5} |=> ser_tx != {1'b0, `D21_5};
  endproperty
  a_forced: assert property (p_forced) else $error("config word while forced");
  property p_ctl; rgmii_rx.ctl_rise == rgmii_rx.ctl_fall; endproperty
  a_ctl: assert property (p_ctl) else $error("control edges differ");
  property p_dup; media_speed != mac_if_pkg::SPEED_1000 && $stable(media_speed) |-> rgmii_rx.d_rise == rgmii_rx.d_fall;
  endproperty
  a_dup: assert property (p_dup) else $error("slow data not repeated");
  property p_clk; $rose(rgmii_rx.clk_rise) && media_speed == mac_if_pkg::SPEED_100
    |=> rgmii_rx.clk_rise[*2] ##1 !rgmii_rx.clk_rise[*2] ##1 rgmii_rx.clk_rise; endproperty
  a_clk: assert property (p_clk) else $error("receive clock period wrong");
  property p_lpbk; mac_loopback && $past(mac_loopback) |=> ser_tx == $past(ser_rx); endproperty
  a_lpbk: assert property (p_lpbk) else $error("loopback echo wrong");
endmodule : mac_if_sva

// [dv/mac_partner.sv]
// MAC-side model.
// Assumes clk is pclk; link clock runs only in frames.
`timescale 1ns/1ps
`include "phy_mac_sel_regs.svh"
module mac_partner (
  input wire logic clk,
  output mac_if_pkg::code_group_t ser_rx,
  output logic txc,
  output logic [3:0] txd,
  output logic tx_ctl
);
  logic busy = 1'b0;
  logic alt = 1'b0;
  // Link clock low until a frame is sent
  initial begin
    txc = 1'b0;
    txd = 4'h0;
    tx_ctl = 1'b0;
    ser_rx = '0;
  end
  // Idle pairs between frames
  always @(posedge clk) begin
    if (!busy) begin
      alt <= !alt;
      ser_rx <= alt ? {1'b0, `D16_2} : {1'b1, `K28_5};
    end
  end
  task automatic send_ser(input int n, input logic [7:0] base, input int rep);
    busy = 1'b1;
    @(posedge clk);
    ser_rx <= {1'b1, `K27_7};
    for (int i = 0; i < n * rep; i++) begin
      @(posedge clk);
      ser_rx <= {1'b0, base + 8'(i / rep)};
    end
    @(posedge clk);
    ser_rx <= {1'b1, `K29_7};
    @(posedge clk);
    busy = 1'b0;
  endtask : send_ser
  task automatic send_rg(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      txd = b[3:0] + 4'(i);
      tx_ctl = 1'b1;
      #31.25 txc = 1'b1;
      #31.25 txd = 4'(b[7:4]);
      #31.25 txc = 1'b0;
      #31.25;
    end
    tx_ctl = 1'b0;
    txd = ~txd; // Released lines show no stale value
  endtask : send_rg
endmodule : mac_partner

// [dv/tb.sv]
// Bench top.
// Assumes partner and checker files.
`timescale 1ns/1ps
`include "phy_mac_sel_regs.svh"
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, rdy;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hDF56;
  logic lpbk = 1'b0, ack = 1'b0, clk_en, txc, ctl, in_frm = 1'b0, hit = 1'b0;
  logic [3:0] txd;
  logic [7:0] b, rg_d;
  mac_if_pkg::speed_t spd = mac_if_pkg::SPEED_1000;
  mac_if_pkg::byte_stream_t core_rx = '0, core_tx;
  mac_if_pkg::code_group_t ser_rx, ser_tx;
  mac_if_pkg::rgmii_ddr_t rgmii_rx;
  int mismatches = 0, n_compared = 0, s_cnt, d_cnt, rep;
  logic [7:0] got[$];
  always #4 pclk = ~pclk;
  phy_mac_interface_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_enable_strap_pin(1'b1), .rgmii_disable_strap_pin(1'b0), .media_speed(spd), .media_link(1'b1),
    .mac_loopback(lpbk), .core_rx(core_rx), .core_rx_ready(rdy), .core_tx(core_tx), .ser_rx(ser_rx),
    .ser_rx_cfg_ack(ack), .ser_tx(ser_tx), .ser_rx_clk_en(clk_en), .rgmii_txc(txc), .rgmii_txd(txd),
    .rgmii_tx_ctl(ctl), .rgmii_rx(rgmii_rx));
  mac_partner mac (.clk(pclk), .ser_rx(ser_rx), .txc(txc), .txd(txd), .tx_ctl(ctl));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, idx, 2'b00, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic send_core(input int n, input logic [7:0] base);
    for (int i = 0; i < n;) begin
      core_rx <= {3'b110, base + 8'(i)};
      @(negedge pclk);
      i += int'(rdy === 1'b1);
      @(posedge pclk);
    end
    core_rx <= '0;
  endtask : send_core
  task automatic chk_q(input logic [7:0] base);
    chk("bytes", got.size(), 3);
    foreach (got[k]) chk("byte", got[k], base + 8'(k));
    got.delete();
  endtask : chk_q
  task automatic report_and_stop;
    $display("Counts: compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Wire monitor on the quiet clock half
  always @(negedge pclk) begin
    if (ser_tx.k === 1'b1) in_frm = ser_tx.data === `K27_7;
    s_cnt += int'(ser_tx === {1'b1, `K27_7});
    d_cnt += int'(in_frm && ser_tx.k === 1'b0);
    if (core_tx.valid === 1'b1) got.push_back(core_tx.data);
    if (rgmii_rx.ctl_rise === 1'b1 && !hit) {hit, rg_d} = {1'b1, rgmii_rx.d_fall, rgmii_rx.d_rise};
  end
  // Watchdog, well past the run
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("four wire", clk_en, 0);
    apb(0, `IDX_PHY_CONTROL, 0);
    chk("strap loaded", rd[`BIT_SERIAL_EN], 1);
    for (int i = 0; i < 4; i++) begin
      apb(1, `IDX_PHY_CONTROL, 32'(!i[1]) << `BIT_SERIAL_EN);
      apb(1, `IDX_RGMII_CONTROL, 32'(!i[0]) << `BIT_RGMII_EN);
      apb(0, `IDX_IFACE_STATUS, 0);
      chk("mode", rd & 7, i < 2 ? 1 << 1 : i == 2 ? 1 << 2 : 1);
    end
    apb(0, `IDX_STRAP_STATUS_ONE, 0);
    chk("strap copy", rd, 1);
    apb(0, 10'h3FF, 0);
    chk("unmapped", rd | 32'(!err), 0);
    $display("test registers done");
    apb(1, `IDX_PHY_CONTROL, 1 << `BIT_SERIAL_EN);
    b = 0;
    repeat (40) @(negedge pclk) b |= 8'(ser_tx === {1'b0, `D21_5});
    chk("config words", b, 1);
    ack <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(0, `IDX_IFACE_STATUS, 0);
    chk("linked", rd[10:8], mac_if_pkg::AN_LINKED);
    spd <= mac_if_pkg::speed_t'(2'(($random(seed) & 32'hFF) % 3));
    apb(1, `IDX_CONFIG_TWO, 1 << `BIT_SIX_WIRE);
    apb(0, `IDX_IFACE_STATUS, 0);
    chk("forced", {rd[10:8], rd[5:4]}, {mac_if_pkg::AN_FORCED, spd});
    chk("six wire", clk_en, 1);
    for (int i = 0; i < 3; i++) begin
      spd <= mac_if_pkg::speed_t'(i);
      rep = i == 0 ? 100 : i == 1 ? 10 : 1;
      {b, s_cnt, d_cnt} = {8'($random(seed)), 64'h0};
      send_core(3, b);
      repeat (rep + 20) @(posedge pclk);
      chk("start once", s_cnt, 1);
      chk("copies", d_cnt, 3 * rep);
      mac.send_ser(3, b, rep);
      repeat (20) @(posedge pclk);
      chk_q(b);
    end
    lpbk <= 1'b1;
    repeat (50) @(posedge pclk);
    lpbk <= 1'b0;
    $display("test serial done");
    apb(1, `IDX_PHY_CONTROL, 0);
    apb(1, `IDX_RGMII_CONTROL, 1 << `BIT_RGMII_EN);
    for (int i = 2; i > 0; i--) begin
      spd <= mac_if_pkg::speed_t'(i);
      {hit, b} = {1'b0, 8'($random(seed))};
      send_core(1, b);
      repeat (30) @(posedge pclk);
      chk("ddr nibbles", rg_d, i == 2 ? b : {2{b[3:0]}});
    end
    spd <= mac_if_pkg::SPEED_1000;
    repeat (30) @(posedge pclk);
    mac.send_rg(3, 8'h21);
    repeat (20) @(posedge pclk);
    chk_q(8'h21);
    $display("test rgmii done");
    report_and_stop();
  end
endmodule : tb
bind phy_mac_interface_select mac_if_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .media_speed(media_speed), .mac_loopback(mac_loopback),
  .ser_rx(ser_rx), .ser_tx(ser_tx), .ser_rx_clk_en(ser_rx_clk_en), .rgmii_rx(rgmii_rx));
